// [pcl_pkg.sv]
package pcl_pkg;

  // ---------------------------------------------------------------------------
  // block sizing
  // ---------------------------------------------------------------------------
  localparam int PCL_SIG_PER_CELL = 8;
  localparam int PCL_ROW_CELLS    = 4;
  localparam int PCL_COL_CELLS    = 5;
  localparam int PCL_ROW_BUNDLE   = PCL_SIG_PER_CELL * PCL_ROW_CELLS;
  localparam int PCL_COL_BUNDLE   = PCL_SIG_PER_CELL * PCL_COL_CELLS;
  localparam int PCL_NUM_PCLK     = 6;
  localparam int PCL_DLY_DEPTH    = 16;

  // ---------------------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  PCL_OFF_CTRL = 8'h00;
  localparam logic [7:0]  PCL_OFF_SEL  = 8'h04;
  localparam logic [7:0]  PCL_OFF_CLR  = 8'h08;
  localparam logic [7:0]  PCL_OFF_DLY  = 8'h0c;
  localparam logic [7:0]  PCL_OFF_STAT = 8'h10;
  localparam logic [31:0] PCL_RST_CTRL = 32'h0000_0001;
  localparam logic [31:0] PCL_RST_SEL  = 32'h0000_0000;
  localparam logic [31:0] PCL_RST_CLR  = 32'h0000_0000;
  localparam logic [31:0] PCL_RST_DLY  = 32'h0000_0000;
  localparam logic [1:0]  PCL_RESP_OK  = 2'h0;
  localparam logic [1:0]  PCL_RESP_ERR = 2'h2;

  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int PCL_C_MODE  = 0;   // two bits
  localparam int PCL_C_DDR   = 2;
  localparam int PCL_C_DRV   = 3;
  localparam int PCL_C_TERM  = 4;
  localparam int PCL_C_P0REG = 5;
  localparam int PCL_C_P1REG = 6;
  localparam int PCL_C_OEBYP = 7;
  localparam int PCL_S_INCLK = 0;   // three bits each
  localparam int PCL_S_INCE  = 3;
  localparam int PCL_S_OCLK  = 6;
  localparam int PCL_S_OCE   = 9;
  localparam int PCL_K_ASRC  = 0;
  localparam int PCL_K_SSRC  = 1;
  localparam int PCL_K_ASW   = 2;
  localparam int PCL_K_SSW   = 3;
  localparam int PCL_K_AIGN  = 4;   // five bits each
  localparam int PCL_K_SIGN  = 9;
  localparam int PCL_K_PRE   = 14;
  localparam int PCL_D_TAP0  = 0;   // four bits each
  localparam int PCL_D_TAP1  = 4;
  localparam int PCL_T_PIN   = 5;
  localparam int PCL_T_TERM  = 6;
  localparam int PCL_T_PATH0 = 7;
  localparam int PCL_T_PATH1 = 8;

  // register order within the cell
  localparam int PCL_Q_IN  = 0;
  localparam int PCL_Q_OHI = 1;
  localparam int PCL_Q_OLO = 2;
  localparam int PCL_Q_EHI = 3;
  localparam int PCL_Q_ELO = 4;

  // source codes: fabric, periphery lines 1..6, row/column line
  localparam logic [2:0] PCL_SRC_LOCAL = 3'h0;
  localparam logic [2:0] PCL_SRC_RC    = 3'h7;

  typedef enum logic [1:0] {
    PCL_MODE_IN   = 2'h1,
    PCL_MODE_OUT  = 2'h2,
    PCL_MODE_BIDI = 2'h3
  } pcl_mode_t;

  typedef enum logic [1:0] {
    PCL_BS_IDLE = 2'h1,
    PCL_BS_RESP = 2'h2
  } pcl_bus_st_t;

  // one cell's share of the fabric bundle
  typedef struct packed {
    logic d_hi;
    logic d_lo;
    logic oe_hi;
    logic oe_lo;
    logic clk;
    logic ce;
    logic aclr;
    logic sclr;
  } pcl_fab_t;

  // both input paths toward the interconnect kinds
  typedef struct packed {
    logic [1:0] row;
    logic [1:0] col;
    logic [1:0] direct;
  } pcl_route_t;

endpackage

// [pcl_pin_cell.sv]
// The address map and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pcl_pin_cell #(
  parameter int         ADDR_W    = 8,
  parameter int         DLY_DEPTH = pcl_pkg::PCL_DLY_DEPTH,
  parameter logic       IS_ROW    = 1'b1
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output var  logic                   s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output var  logic                   s_axi_wready,
  output var  logic [1:0]             s_axi_bresp,
  output var  logic                   s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [ADDR_W-1:0]      s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output var  logic                   s_axi_arready,
  output var  logic [31:0]            s_axi_rdata,
  output var  logic [1:0]             s_axi_rresp,
  output var  logic                   s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire pcl_pkg::pcl_fab_t      fab,
  input  wire logic [5:0]             io_clk,
  input  wire logic                   rc_clk,
  input  wire logic                   rc_ce,
  input  wire logic                   pin_i,
  output var  logic                   pin_o,
  output var  logic                   pin_oe,
  output var  logic                   term_en,
  output var  pcl_pkg::pcl_route_t    route
);

  localparam int TW = $clog2(DLY_DEPTH);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [31:0]          ctrl, next_ctrl;
  logic [31:0]          sel, next_sel;
  logic [31:0]          clr, next_clr;
  logic [31:0]          dly, next_dly;
  pcl_pkg::pcl_bus_st_t wst, next_wst;
  pcl_pkg::pcl_bus_st_t rst_st, next_rst_st;
  logic                 aw_hold, next_aw_hold;
  logic                 w_hold, next_w_hold;
  logic [ADDR_W-1:0]    waddr, next_waddr;
  logic [31:0]          wdata, next_wdata;
  logic [3:0]           wstrb, next_wstrb;
  logic                 next_awready, next_wready, next_bvalid;
  logic [1:0]           next_bresp, next_rresp;
  logic                 next_arready, next_rvalid;
  logic [31:0]          next_rdata;
  logic [4:0]           q, next_q;
  logic                 in_clk_prev, out_clk_prev;
  logic [DLY_DEPTH-1:0] chain, next_chain;
  logic                 next_pin_o, next_pin_oe, next_term_en;
  pcl_pkg::pcl_route_t  next_route;

  // ---------------------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------------------
  // code 0 local cluster, 1..6 periphery line, 7 row/column line
  function automatic logic pick(input logic [2:0] code, input logic loc,
                                input logic [5:0] pclk, input logic rc);
    logic v;
    v = loc;
    if (code == pcl_pkg::PCL_SRC_RC)
      v = rc;
    else if (code != pcl_pkg::PCL_SRC_LOCAL)
      v = pclk[code - 3'h1];
    return v;
  endfunction

  logic in_clk, in_ce, out_clk, out_ce;
  logic in_tick, out_rise, out_fall;
  logic aclr_now, sclr_now;
  logic ddr;
  logic tap0, tap1, path0, path1;
  logic wr_do, wr_hit;

  // each cell picks its own clocks, enables and clear sources
  always_comb begin
    in_clk  = pick(sel[pcl_pkg::PCL_S_INCLK +: 3], fab.clk, io_clk,
                   rc_clk);
    in_ce   = pick(sel[pcl_pkg::PCL_S_INCE +: 3], fab.ce, io_clk,
                   rc_ce);
    out_clk = pick(sel[pcl_pkg::PCL_S_OCLK +: 3], fab.clk, io_clk,
                   rc_clk);
    out_ce  = pick(sel[pcl_pkg::PCL_S_OCE +: 3], fab.ce, io_clk,
                   rc_ce);
    aclr_now = clr[pcl_pkg::PCL_K_ASRC] ? clr[pcl_pkg::PCL_K_ASW]
                                        : fab.aclr;
    sclr_now = clr[pcl_pkg::PCL_K_SSRC] ? clr[pcl_pkg::PCL_K_SSW]
                                        : fab.sclr;
    ddr      = ctrl[pcl_pkg::PCL_C_DDR];
    in_tick  = in_clk & ~in_clk_prev;
    // one shared edge pair feeds both output and enable registers
    out_rise = out_clk & ~out_clk_prev;
    out_fall = ~out_clk & out_clk_prev & ddr;
  end

  // ---------------------------------------------------------------------------
  // input delay chain and paths
  // ---------------------------------------------------------------------------
  // one shift line serves both paths; each tap is its own delay
  always_comb begin
    next_chain = {chain[DLY_DEPTH-2:0], pin_i};
    tap0 = chain[dly[pcl_pkg::PCL_D_TAP0 +: TW]];
    tap1 = chain[dly[pcl_pkg::PCL_D_TAP1 +: TW]];
    path0 = ctrl[pcl_pkg::PCL_C_P0REG] ? q[pcl_pkg::PCL_Q_IN] : tap0;
    path1 = ctrl[pcl_pkg::PCL_C_P1REG] ? q[pcl_pkg::PCL_Q_IN] : tap1;
    next_route.col    = {path1, path0};
    next_route.row    = IS_ROW ? {path1, path0} : 2'h0;
    next_route.direct = IS_ROW ? {path1, path0} : 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain        <= '0;
      route        <= '0;
      in_clk_prev  <= 1'b0;
      out_clk_prev <= 1'b0;
    end else begin
      chain        <= next_chain;
      route        <= next_route;
      in_clk_prev  <= in_clk;
      out_clk_prev <= out_clk;
    end
  end

  // ---------------------------------------------------------------------------
  // the five cell registers
  // ---------------------------------------------------------------------------
  // async clear beats everything and needs no edge; sync clear waits for
  // the register's own edge, even with its clock enable low
  always_comb begin
    logic [4:0] d;
    logic [4:0] edge_v;
    logic [4:0] ce_v;
    d      = {fab.oe_lo, fab.oe_hi, fab.d_lo, fab.d_hi, tap0};
    edge_v = {out_fall, out_rise, out_fall, out_rise, in_tick};
    ce_v   = {out_ce, out_ce, out_ce, out_ce, in_ce};
    next_q = q;
    for (int i = 0; i < 5; i++) begin
      if (aclr_now && !clr[pcl_pkg::PCL_K_AIGN + i])
        next_q[i] = clr[pcl_pkg::PCL_K_PRE + i];
      else if (edge_v[i] && sclr_now && !clr[pcl_pkg::PCL_K_SIGN + i])
        next_q[i] = clr[pcl_pkg::PCL_K_PRE + i];
      else if (edge_v[i] && ce_v[i])
        next_q[i] = d[i];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      q <= '0;
    else
      q <= next_q;
  end

  // ---------------------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------------------
  // the pin follows the live output clock level, so each half period
  // shows one cycle later than the edge that loaded its register
  always_comb begin
    logic dat;
    logic en;
    dat = q[pcl_pkg::PCL_Q_OHI];
    en  = q[pcl_pkg::PCL_Q_EHI];
    if (ddr && !out_clk) begin
      dat = q[pcl_pkg::PCL_Q_OLO];
      en  = q[pcl_pkg::PCL_Q_ELO];
    end
    if (ctrl[pcl_pkg::PCL_C_OEBYP])
      en = fab.oe_hi;
    case (pcl_pkg::pcl_mode_t'(ctrl[pcl_pkg::PCL_C_MODE +: 2]))
      pcl_pkg::PCL_MODE_OUT:  en = 1'b1;
      pcl_pkg::PCL_MODE_BIDI: en = en;
      default:                en = 1'b0;
    endcase
    next_pin_oe  = en;
    next_pin_o   = en & dat;
    next_term_en = ctrl[pcl_pkg::PCL_C_TERM] &
                   ~ctrl[pcl_pkg::PCL_C_DRV];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_o   <= 1'b0;
      pin_oe  <= 1'b0;
      term_en <= 1'b0;
    end else begin
      pin_o   <= next_pin_o;
      pin_oe  <= next_pin_oe;
      term_en <= next_term_en;
    end
  end

  // ---------------------------------------------------------------------------
  // bus write side
  // ---------------------------------------------------------------------------
  // address and data are taken in any order; ready stays low until the
  // response is accepted, so only one write is ever in flight
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold  = w_hold;
    next_waddr   = waddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_awready = s_axi_awready;
    next_wready  = s_axi_wready;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_wst     = wst;
    wr_do        = 1'b0;
    wr_hit       = 1'b0;
    case (wst)
      pcl_pkg::PCL_BS_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          next_aw_hold = 1'b1;
          next_waddr   = s_axi_awaddr;
          next_awready = 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          next_w_hold = 1'b1;
          next_wdata  = s_axi_wdata;
          next_wstrb  = s_axi_wstrb;
          next_wready = 1'b0;
        end
        if (aw_hold && w_hold) begin
          wr_do  = 1'b1;
          wr_hit = (waddr[7:0] == pcl_pkg::PCL_OFF_CTRL) ||
                   (waddr[7:0] == pcl_pkg::PCL_OFF_SEL) ||
                   (waddr[7:0] == pcl_pkg::PCL_OFF_CLR) ||
                   (waddr[7:0] == pcl_pkg::PCL_OFF_DLY) ||
                   (waddr[7:0] == pcl_pkg::PCL_OFF_STAT);
          next_aw_hold = 1'b0;
          next_w_hold  = 1'b0;
          next_bvalid  = 1'b1;
          next_bresp   = wr_hit ? pcl_pkg::PCL_RESP_OK : pcl_pkg::PCL_RESP_ERR;
          next_wst     = pcl_pkg::PCL_BS_RESP;
        end
      end
      pcl_pkg::PCL_BS_RESP: begin
        if (s_axi_bready) begin
          next_bvalid  = 1'b0;
          next_awready = 1'b1;
          next_wready  = 1'b1;
          next_wst     = pcl_pkg::PCL_BS_IDLE;
        end
      end
      default: next_wst = pcl_pkg::PCL_BS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst           <= pcl_pkg::PCL_BS_IDLE;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      waddr         <= '0;
      wdata         <= '0;
      wstrb         <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pcl_pkg::PCL_RESP_OK;
    end else begin
      wst           <= next_wst;
      aw_hold       <= next_aw_hold;
      w_hold        <= next_w_hold;
      waddr         <= next_waddr;
      wdata         <= next_wdata;
      wstrb         <= next_wstrb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // ---------------------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------------------
  // byte lanes honoured; the status word ignores writes
  always_comb begin
    logic [31:0] m;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = {8{wstrb[b]}};
    next_ctrl = ctrl;
    next_sel  = sel;
    next_clr  = clr;
    next_dly  = dly;
    if (wr_do) begin
      case (waddr[7:0])
        pcl_pkg::PCL_OFF_CTRL: next_ctrl = (ctrl & ~m) | (wdata & m);
        pcl_pkg::PCL_OFF_SEL:  next_sel  = (sel & ~m) | (wdata & m);
        pcl_pkg::PCL_OFF_CLR:  next_clr  = (clr & ~m) | (wdata & m);
        pcl_pkg::PCL_OFF_DLY:  next_dly  = (dly & ~m) | (wdata & m);
        default:               next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= pcl_pkg::PCL_RST_CTRL;
      sel  <= pcl_pkg::PCL_RST_SEL;
      clr  <= pcl_pkg::PCL_RST_CLR;
      dly  <= pcl_pkg::PCL_RST_DLY;
    end else begin
      ctrl <= next_ctrl;
      sel  <= next_sel;
      clr  <= next_clr;
      dly  <= next_dly;
    end
  end

  // ---------------------------------------------------------------------------
  // bus read side
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] stat;
    stat = '0;
    stat[4:0]                   = q;
    stat[pcl_pkg::PCL_T_PIN]   = pin_i;
    stat[pcl_pkg::PCL_T_TERM]  = term_en;
    stat[pcl_pkg::PCL_T_PATH0] = path0;
    stat[pcl_pkg::PCL_T_PATH1] = path1;
    next_arready = s_axi_arready;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    next_rst_st  = rst_st;
    case (rst_st)
      pcl_pkg::PCL_BS_IDLE: begin
        if (s_axi_arvalid) begin
          next_arready = 1'b0;
          next_rvalid  = 1'b1;
          next_rresp   = pcl_pkg::PCL_RESP_OK;
          next_rst_st  = pcl_pkg::PCL_BS_RESP;
          case (s_axi_araddr[7:0])
            pcl_pkg::PCL_OFF_CTRL: next_rdata = ctrl;
            pcl_pkg::PCL_OFF_SEL:  next_rdata = sel;
            pcl_pkg::PCL_OFF_CLR:  next_rdata = clr;
            pcl_pkg::PCL_OFF_DLY:  next_rdata = dly;
            pcl_pkg::PCL_OFF_STAT: next_rdata = stat;
            default: begin
              next_rdata = '0;
              next_rresp = pcl_pkg::PCL_RESP_ERR;
            end
          endcase
        end
      end
      pcl_pkg::PCL_BS_RESP: begin
        if (s_axi_rready) begin
          next_rvalid  = 1'b0;
          next_arready = 1'b1;
          next_rst_st  = pcl_pkg::PCL_BS_IDLE;
        end
      end
      default: next_rst_st = pcl_pkg::PCL_BS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_st        <= pcl_pkg::PCL_BS_IDLE;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= pcl_pkg::PCL_RESP_OK;
    end else begin
      rst_st        <= next_rst_st;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

endmodule
`default_nettype wire

// [pcl_pin_cell_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module pcl_pin_cell_monitor #(
  parameter logic IS_ROW = 1'b1
) (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic                pin_o,
  input wire logic                pin_oe,
  input wire pcl_pkg::pcl_route_t route
);
  // ----------------------------------------
  // bus and pin relations
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RST_IDLE: assert property (disable iff (1'b0) !aresetn |=>
    s_axi_awready && s_axi_arready && !s_axi_bvalid && !pin_oe)
    else $error("not idle after reset");
  AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
    else $error("write answer late");
  AST_W_BUSY: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> (!s_axi_awready && !s_axi_wready) [*2])
    else $error("write taken while busy");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready)
    else $error("write answer not closed");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_arready ##[0:1] s_axi_rvalid)
    else $error("read answer late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_OE_REL: assert property (!pin_oe |-> !pin_o)
    else $error("pin driven while released");
  AST_COL_ONLY: assert property (!IS_ROW |->
    route.row == 2'h0 && route.direct == 2'h0)
    else $error("column cell drives row lines");

  // main scenarios seen
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(pin_oe));
endmodule

bind pcl_pin_cell pcl_pin_cell_monitor #(.IS_ROW(IS_ROW))
  pcl_pin_cell_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .pin_o, .pin_oe, .route);
`default_nettype wire

// [pcl_fabric_model.sv]
`timescale 1ns/100ps
`default_nettype none
module pcl_fabric_model (
  input  wire logic              aclk,
  input  wire logic              run,
  input  wire logic [2:0]        line,
  input  wire logic [3:0]        half,
  input  wire logic [3:0]        ctl,
  input  wire logic [2:0]        lvl,
  output var  pcl_pkg::pcl_fab_t fab,
  output var  logic [5:0]        io_clk,
  output var  logic              rc_clk,
  output var  logic              rc_ce
);
  // ----------------------------------------
  // fabric clock and control drive
  // ----------------------------------------
  logic [3:0] cnt = 4'h0;
  logic       gclk = 1'b0;

  // clock stands low between bursts; half sets prompt or slow pace
  always_ff @(posedge aclk) begin
    if (!run) begin
      cnt <= 4'h0;
      gclk <= 1'b0;
    end else if (cnt == half) begin
      cnt <= 4'h0;
      gclk <= !gclk;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end

  // only the chosen line toggles, so a wrong source pick loads nothing
  always_comb begin
    fab = {ctl, gclk && line == 3'h0, lvl};
    for (int k = 0; k < 6; k++) io_clk[k] = gclk && line == 3'(k + 1);
    rc_clk = gclk && line == 3'h7;
    rc_ce = lvl[2];
  end
endmodule
`default_nettype wire

// [pcl_pin_cell_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module pcl_pin_cell_tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic [7:0]          s_axi_awaddr = 8'h00;
  logic                s_axi_awvalid = 1'b0;
  logic [31:0]         s_axi_wdata = 32'h0;
  logic [3:0]          s_axi_wstrb = 4'hf;
  logic                s_axi_wvalid = 1'b0;
  logic                s_axi_bready = 1'b0;
  logic [7:0]          s_axi_araddr = 8'h00;
  logic                s_axi_arvalid = 1'b0;
  logic                s_axi_rready = 1'b0;
  logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                s_axi_arready, s_axi_rvalid;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic [31:0]         s_axi_rdata;
  pcl_pkg::pcl_fab_t   fab;
  pcl_pkg::pcl_route_t route;
  logic [5:0]          io_clk;
  logic                rc_clk, rc_ce, pin_i, pin_o, pin_oe, term_en;
  logic                run = 1'b0;
  logic                pin_ext = 1'b0;
  logic [2:0]          line = 3'h0;
  logic [3:0]          half = 4'h1;
  logic [3:0]          ctl = 4'h0;
  logic [2:0]          lvl = 3'h4;
  int                  miscompares = 0;
  int                  checks_done = 0;
  int                  cycles = 0;

  // pin level: the cell when it drives, else the outside world
  assign pin_i = pin_oe ? pin_o : pin_ext;
  always #20 aclk = !aclk;

  pcl_pin_cell #(.IS_ROW(1'b0)) pcl_pin_cell_i (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fab, .io_clk, .rc_clk, .rc_ce,
    .pin_i, .pin_o, .pin_oe, .term_en, .route);
  pcl_fabric_model pcl_fabric_model_i (.aclk, .run, .line, .half, .ctl,
    .lvl, .fab, .io_clk, .rc_clk, .rc_ce);

  // watchdog: a hang ends the run as a failure
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t value %h not %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t pin %b not %b", $time, got, exp);
    end
  endtask

  // slow master raises bready only once the answer shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic slow);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !slow;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid && s_axi_bready;
      if (done) s_axi_bready <= 1'b0;
      else if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    chk_reg(32'(s_axi_bresp), 32'(pcl_pkg::PCL_RESP_OK));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er, input logic slow);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !slow;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid && s_axi_rready;
      if (done) s_axi_rready <= 1'b0;
      else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    chk_reg(s_axi_rdata, exp);
    chk_reg(32'(s_axi_rresp), 32'(er));
  endtask

  // one clock burst on a line, then time for load and pin update
  task automatic pulse(input logic [2:0] ln);
    line <= ln;
    run <= 1'b1;
    repeat (8) @(posedge aclk);
    run <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic burst(output int n0, output int n1);
    n0 = 0;
    n1 = 0;
    run <= 1'b1;
    repeat (48) begin
      @(posedge aclk);
      if (pin_o === 1'b0) n0++;
      if (pin_o === 1'b1) n1++;
    end
    run <= 1'b0;
  endtask

  task automatic t_reset();
    rd(pcl_pkg::PCL_OFF_CTRL, pcl_pkg::PCL_RST_CTRL, 2'h0, 1'b0);
    rd(pcl_pkg::PCL_OFF_SEL, pcl_pkg::PCL_RST_SEL, 2'h0, 1'b1);
    rd(pcl_pkg::PCL_OFF_CLR, pcl_pkg::PCL_RST_CLR, 2'h0, 1'b0);
    rd(pcl_pkg::PCL_OFF_DLY, pcl_pkg::PCL_RST_DLY, 2'h0, 1'b0);
    rd(8'h20, 32'h0, pcl_pkg::PCL_RESP_ERR, 1'b0);
  endtask

  task automatic t_input();
    pin_ext <= 1'b1;
    repeat (6) @(posedge aclk);
    chk_reg(32'(route), 32'h0c);
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h21, 1'b1);
    repeat (3) @(posedge aclk);
    chk_reg(32'(route), 32'h08);
    pulse(3'h0);
    chk_reg(32'(route), 32'h0c);
  endtask

  // every clock source in turn, data flipping each time
  task automatic t_output();
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h2, 1'b0);
    for (int c = 0; c < 8; c++) begin
      ctl <= {!c[0], 3'b010};
      wr(pcl_pkg::PCL_OFF_SEL, 32'(c) << 6, 1'b0);
      pulse(3'(c));
      chk_bit(pin_o, !c[0]);
      chk_bit(pin_oe, 1'b1);
    end
  endtask

  task automatic t_bidir();
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h3, 1'b0);
    wr(pcl_pkg::PCL_OFF_SEL, 32'h0, 1'b0);
    ctl <= 4'h8;
    pulse(3'h0);
    chk_bit(pin_oe, 1'b0);
    chk_bit(pin_o, 1'b0);
    ctl <= 4'ha;
    pulse(3'h0);
    chk_bit(pin_oe, 1'b1);
    chk_bit(pin_o, 1'b1);
  endtask

  task automatic t_term();
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h1a, 1'b1);
    repeat (3) @(posedge aclk);
    chk_bit(term_en, 1'b0);
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h12, 1'b0);
    repeat (3) @(posedge aclk);
    chk_bit(term_en, 1'b1);
  endtask

  // clear hits once obeyed, once ignored by the high output register
  task automatic t_clear();
    for (int k = 0; k < 2; k++) begin
      wr(pcl_pkg::PCL_OFF_CLR, k ? 32'h20 : 32'h0, 1'b0);
      pulse(3'h0);
      lvl <= 3'h6;
      repeat (3) @(posedge aclk);
      lvl <= 3'h4;
      repeat (2) @(posedge aclk);
      chk_bit(pin_o, 1'(k));
    end
  endtask

  task automatic t_ddr();
    int n0;
    int n1;
    half <= 4'h3;
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h6, 1'b0);
    burst(n0, n1);
    chk_bit(n0 > 0 && n1 > 0, 1'b1);
    wr(pcl_pkg::PCL_OFF_CTRL, 32'h2, 1'b0);
    burst(n0, n1);
    chk_bit(n1 == 48, 1'b1);
  endtask

  task automatic finish_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_input();
    t_output();
    t_bidir();
    t_term();
    t_clear();
    t_ddr();
    finish_test();
  end
endmodule
`default_nettype wire
